// >>> design/vamc_defines.svh
// register offsets, field positions and reset values of the acquisition/mode register bank
`ifndef VAMC_DEFINES_SVH
`define VAMC_DEFINES_SVH
`define VAMC_ADDR_CLAMP_START   8'h58
`define VAMC_ADDR_CLAMP_STOP    8'h59
`define VAMC_ADDR_WIN_START     8'h5A
`define VAMC_ADDR_WIN_STOP      8'h5B
`define VAMC_ADDR_HORIZ_EXT     8'h5C
`define VAMC_ADDR_VSYNC_ONE     8'h5D
`define VAMC_ADDR_VSYNC_TWO     8'h5E
`define VAMC_ADDR_MODE_ZERO     8'h60
`define VAMC_ADDR_MODE_ONE      8'h61
`define VAMC_ADDR_FIELD_LOW     8'h80
`define VAMC_ADDR_FIELD_HIGH    8'h81
`define VAMC_REG_RESET          8'h00
`define VAMC_EXT_START_MSB      0
`define VAMC_EXT_STOP_MSB       1
`define VAMC_EXT_DELAY_LSB      2
`define VAMC_EXT_DELAY_MSB      3
`define VAMC_EXT_PHASE          4
`define VAMC_EXT_RECOG_MODE     5
`define VAMC_EXT_RECOG_DIS      6
`define VAMC_M0_ACQ_LO          0
`define VAMC_M0_ACQ_HI          1
`define VAMC_M0_DISP_LO         2
`define VAMC_M0_DISP_HI         3
`define VAMC_M0_DOUBLE          4
`define VAMC_M0_PIP_EN          5
`define VAMC_M0_PIP_GRID        6
`define VAMC_M0_GEN_MODE        7
`define VAMC_M1_RASTER          0
`define VAMC_M1_FREEZE_ONE      1
`define VAMC_M1_FREEZE_TWO      2
`define VAMC_M1_OUT_LO          3
`define VAMC_M1_DEFL_CLK        4
`define VAMC_M1_OUT_HI          5
`define VAMC_M1_EXT_CLK         6
`define VAMC_M1_VRATE           7
`define VAMC_FI_LEN8            0
`define VAMC_FI_LEN9            1
`define VAMC_FI_CNT_LSB         2
`define VAMC_FI_RECOG           3
`define VAMC_FI_CNT_MSB         4
`endif

// >>> design/vamc_pkg.sv
// types of the acquisition/mode register bank
package vamc_pkg;
  typedef enum logic [1:0] {VAMC_ACQ_12M0, VAMC_ACQ_13M5, VAMC_ACQ_16M0, VAMC_ACQ_18M0} vamc_acq_freq_t;
  typedef enum logic [1:0] {VAMC_DISP_27M0, VAMC_DISP_32M0, VAMC_DISP_36M0} vamc_disp_freq_t;
  typedef enum logic [2:0] {
    VAMC_RASTER_ABAB_100, VAMC_RASTER_AABB_100, VAMC_PROG_625, VAMC_INTL_1250,
    VAMC_SINGLE_312, VAMC_RASTER_ILLEGAL
  } vamc_disp_mode_t;
  typedef struct packed {
    logic [8:0] win_start;
    logic [8:0] win_stop;
    logic [1:0] fine_delay;
    logic       clk_phase;
    logic       recog_mode;
    logic       recog_disable;
  } vamc_acq_cfg_t;
  typedef struct packed {
    vamc_acq_freq_t  acq_freq;
    vamc_disp_freq_t disp_freq;
    logic            acq_double;
    logic            pip_enable;
    logic            pip_grid_4x4;
    logic            generator_mode;
    logic            deflection_clockgen;
    logic            external_acq_clock;
    logic            vert_rate_50;
    vamc_disp_mode_t disp_mode;
  } vamc_mode_cfg_t;
  typedef struct packed {
    logic [9:0] field_length;
    logic [1:0] field_count;
    logic       field_recog;
  } vamc_field_info_t;
endpackage

// >>> design/vamc_regs.sv
// acquisition timing, mode and field-information register bank on the 8-bit host port
`timescale 1ns/10ps
`include "vamc_defines.svh"

module vamc_regs
  import vamc_pkg::*;
(
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  // host parallel port
  input  wire logic [7:0]       host_addr,
  input  wire logic [7:0]       host_wdata,
  input  wire logic             host_wr,
  input  wire logic             host_rd,
  output logic [7:0]            host_rdata,
  // measured field state
  input  wire logic [9:0]       meas_field_length,
  input  wire logic             meas_length_valid,
  input  wire logic [1:0]       disp_field_count,
  input  wire logic             field_recog_result,
  // external pins and display signals
  input  wire logic             single_clock_input,
  input  wire logic             strobe,
  input  wire logic             horiz_display_signal,
  input  wire logic             vert_display_signal,
  // configuration towards acquisition and display logic
  output logic [7:0]            clamp_start_pos,
  output logic [7:0]            clamp_stop_pos,
  output logic [7:0]            vsync_sample_one_pos,
  output logic [7:0]            vsync_sample_two_pos,
  output vamc_acq_cfg_t         acq_cfg,
  output vamc_mode_cfg_t        mode_cfg,
  output logic                  mem_one_input_enable,
  output logic                  mem_two_write_enable,
  output logic                  field_measure_enable,
  output logic                  display_out_signal
);

  // ----------------------------------------------------------------
  // writable registers
  // ----------------------------------------------------------------
  logic [7:0]       clamp_start;
  logic [7:0]       clamp_stop;
  logic [7:0]       acq_write_window_start;
  logic [7:0]       acq_write_window_stop;
  logic [7:0]       acq_horiz_extension;
  logic [7:0]       vsync_sample_pulse_one;
  logic [7:0]       vsync_sample_pulse_two;
  logic [7:0]       mode_zero;
  logic [7:0]       mode_one;
  logic [9:0]       field_length;
  vamc_disp_mode_t  next_disp_mode;
  logic [7:0]       next_rdata;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      clamp_start            <= `VAMC_REG_RESET;
      clamp_stop             <= `VAMC_REG_RESET;
      acq_write_window_start <= `VAMC_REG_RESET;
      acq_write_window_stop  <= `VAMC_REG_RESET;
      acq_horiz_extension    <= `VAMC_REG_RESET;
      vsync_sample_pulse_one <= `VAMC_REG_RESET;
      vsync_sample_pulse_two <= `VAMC_REG_RESET;
      mode_zero              <= `VAMC_REG_RESET;
      mode_one               <= `VAMC_REG_RESET;
    end else if (host_wr) begin
      if (host_addr == `VAMC_ADDR_CLAMP_START) begin
        clamp_start <= host_wdata;
      end else if (host_addr == `VAMC_ADDR_CLAMP_STOP) begin
        clamp_stop <= host_wdata;
      end else if (host_addr == `VAMC_ADDR_WIN_START) begin
        acq_write_window_start <= host_wdata;
      end else if (host_addr == `VAMC_ADDR_WIN_STOP) begin
        acq_write_window_stop <= host_wdata;
      end else if (host_addr == `VAMC_ADDR_HORIZ_EXT) begin
        acq_horiz_extension <= {1'b0, host_wdata[6:0]};
      end else if (host_addr == `VAMC_ADDR_VSYNC_ONE) begin
        vsync_sample_pulse_one <= host_wdata;
      end else if (host_addr == `VAMC_ADDR_VSYNC_TWO) begin
        vsync_sample_pulse_two <= host_wdata;
      end else if (host_addr == `VAMC_ADDR_MODE_ZERO) begin
        mode_zero <= host_wdata;
      end else if (host_addr == `VAMC_ADDR_MODE_ONE) begin
        mode_one <= host_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // field length capture
  // ----------------------------------------------------------------
  // held while generator mode runs so software reads the last real field
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      field_length <= 10'h000;
    end else if (meas_length_valid && !mode_zero[`VAMC_M0_GEN_MODE]) begin
      field_length <= meas_field_length;
    end
  end

  // ----------------------------------------------------------------
  // configuration outputs
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      clamp_start_pos      <= 8'h00;
      clamp_stop_pos       <= 8'h00;
      vsync_sample_one_pos <= 8'h00;
      vsync_sample_two_pos <= 8'h00;
      acq_cfg              <= '0;
    end else begin
      clamp_start_pos          <= clamp_start;
      clamp_stop_pos           <= clamp_stop;
      vsync_sample_one_pos     <= vsync_sample_pulse_one;
      vsync_sample_two_pos     <= vsync_sample_pulse_two;
      acq_cfg.win_start        <= {acq_horiz_extension[`VAMC_EXT_START_MSB], acq_write_window_start};
      acq_cfg.win_stop         <= {acq_horiz_extension[`VAMC_EXT_STOP_MSB], acq_write_window_stop};
      acq_cfg.fine_delay       <= acq_horiz_extension[`VAMC_EXT_DELAY_MSB:`VAMC_EXT_DELAY_LSB];
      acq_cfg.clk_phase        <= acq_horiz_extension[`VAMC_EXT_PHASE];
      acq_cfg.recog_mode       <= acq_horiz_extension[`VAMC_EXT_RECOG_MODE];
      acq_cfg.recog_disable    <= acq_horiz_extension[`VAMC_EXT_RECOG_DIS];
    end
  end

  // ----------------------------------------------------------------
  // display mode decode
  // ----------------------------------------------------------------
  // illegal combinations are flagged rather than guessed
  always_comb begin
    next_disp_mode = VAMC_RASTER_ILLEGAL;
    case ({mode_one[`VAMC_M1_VRATE], single_clock_input, mode_one[`VAMC_M1_RASTER]})
      3'b000: next_disp_mode = VAMC_RASTER_ABAB_100;
      3'b001: next_disp_mode = VAMC_RASTER_AABB_100;
      3'b100: next_disp_mode = VAMC_PROG_625;
      3'b101: next_disp_mode = VAMC_INTL_1250;
      3'b110: next_disp_mode = VAMC_SINGLE_312;
      default: next_disp_mode = VAMC_RASTER_ILLEGAL;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mode_cfg <= '0;
    end else begin
      mode_cfg.acq_freq            <= vamc_acq_freq_t'(mode_zero[`VAMC_M0_ACQ_HI:`VAMC_M0_ACQ_LO]);
      mode_cfg.disp_freq           <= mode_zero[`VAMC_M0_DISP_HI] ?
                                      (mode_zero[`VAMC_M0_DISP_LO] ? VAMC_DISP_36M0 : VAMC_DISP_32M0) :
                                      VAMC_DISP_27M0;
      mode_cfg.acq_double          <= mode_zero[`VAMC_M0_DOUBLE];
      mode_cfg.pip_enable          <= mode_zero[`VAMC_M0_PIP_EN];
      mode_cfg.pip_grid_4x4        <= mode_zero[`VAMC_M0_PIP_GRID];
      mode_cfg.generator_mode      <= mode_zero[`VAMC_M0_GEN_MODE];
      mode_cfg.deflection_clockgen <= mode_one[`VAMC_M1_DEFL_CLK];
      mode_cfg.external_acq_clock  <= mode_one[`VAMC_M1_EXT_CLK];
      mode_cfg.vert_rate_50        <= mode_one[`VAMC_M1_VRATE];
      mode_cfg.disp_mode           <= next_disp_mode;
    end
  end

  // ----------------------------------------------------------------
  // memory enables and display output
  // ----------------------------------------------------------------
  // strobe is not sampled: the pip module must be synchronous to the write clock
  assign mem_one_input_enable = !mode_one[`VAMC_M1_FREEZE_ONE] || strobe;
  assign mem_two_write_enable = !mode_one[`VAMC_M1_FREEZE_TWO];
  assign field_measure_enable = !mode_zero[`VAMC_M0_GEN_MODE];

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      display_out_signal <= 1'b0;
    end else if (mode_one[`VAMC_M1_OUT_HI]) begin
      display_out_signal <= horiz_display_signal & vert_display_signal;
    end else if (mode_one[`VAMC_M1_OUT_LO]) begin
      display_out_signal <= vert_display_signal;
    end else begin
      display_out_signal <= horiz_display_signal;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // write-only registers and unmapped offsets read as zero
  always_comb begin
    next_rdata = 8'h00;
    if (host_addr == `VAMC_ADDR_FIELD_LOW) begin
      next_rdata = field_length[7:0];
    end else if (host_addr == `VAMC_ADDR_FIELD_HIGH) begin
      next_rdata[`VAMC_FI_LEN8]    = field_length[8];
      next_rdata[`VAMC_FI_LEN9]    = field_length[9];
      next_rdata[`VAMC_FI_CNT_LSB] = disp_field_count[0];
      next_rdata[`VAMC_FI_RECOG]   = field_recog_result;
      next_rdata[`VAMC_FI_CNT_MSB] = disp_field_count[1];
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      host_rdata <= 8'h00;
    end else if (host_rd) begin
      host_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_reset_clears_mode: assert property (@(posedge mclk) sys_rst |=> (mode_zero == 8'h00 && mode_one == 8'h00))
    else $error("mode registers not cleared by reset");

  a_window_msb_join: assert property (@(posedge mclk) disable iff (sys_rst)
    host_wr && host_addr == `VAMC_ADDR_HORIZ_EXT ##1 !host_wr |=> acq_cfg.win_start[8] == $past(host_wdata[0], 2))
    else $error("window start top bit not taken from extension");

  a_ext_bit7_ignored: assert property (@(posedge mclk) disable iff (sys_rst) !acq_horiz_extension[7])
    else $error("extension bit 7 stored");

  a_freeze_with_strobe: assert property (@(posedge mclk) disable iff (sys_rst)
    mode_one[`VAMC_M1_FREEZE_ONE] && !strobe |-> !mem_one_input_enable)
    else $error("memory one written while frozen");

  a_freeze_mem_two: assert property (@(posedge mclk) disable iff (sys_rst)
    mem_two_write_enable == !mode_one[`VAMC_M1_FREEZE_TWO])
    else $error("memory two enable mismatch");

  a_gen_holds_length: assert property (@(posedge mclk) disable iff (sys_rst)
    mode_zero[`VAMC_M0_GEN_MODE] |=> $stable(field_length))
    else $error("field length changed in generator mode");

  a_disp_freq_27: assert property (@(posedge mclk) disable iff (sys_rst)
    !mode_zero[`VAMC_M0_DISP_HI] && !host_wr |=> mode_cfg.disp_freq == VAMC_DISP_27M0)
    else $error("display clock not 27 MHz");

  a_acq_freq_sel: assert property (@(posedge mclk) disable iff (sys_rst)
    !host_wr |=> mode_cfg.acq_freq == $past(mode_zero[1:0]))
    else $error("acquisition clock select mismatch");

  a_composite_out: assert property (@(posedge mclk) disable iff (sys_rst)
    mode_one[`VAMC_M1_OUT_HI] |=> display_out_signal == $past(horiz_display_signal & vert_display_signal))
    else $error("composite output not anded");

  a_read_length_low: assert property (@(posedge mclk) disable iff (sys_rst)
    host_rd && host_addr == `VAMC_ADDR_FIELD_LOW |=> host_rdata == $past(field_length[7:0]))
    else $error("field length low read wrong");

  a_read_recog_bit: assert property (@(posedge mclk) disable iff (sys_rst)
    host_rd && host_addr == `VAMC_ADDR_FIELD_HIGH |=> host_rdata[3] == $past(field_recog_result))
    else $error("recognition bit read wrong");

  a_read_length_high: assert property (@(posedge mclk) disable iff (sys_rst)
    host_rd && host_addr == `VAMC_ADDR_FIELD_HIGH |=> host_rdata[1:0] == $past(field_length[9:8]))
    else $error("field length high bits read wrong");

  a_read_count_bits: assert property (@(posedge mclk) disable iff (sys_rst)
    host_rd && host_addr == `VAMC_ADDR_FIELD_HIGH |=>
    host_rdata[4] == $past(disp_field_count[1]) && host_rdata[2] == $past(disp_field_count[0]))
    else $error("display field count read wrong");

  // ----------------------------------------------------------------
  // write to output checks
  // ----------------------------------------------------------------
  // load checks look two edges past the write: register first, registered output next; decode checks one edge past the register
  a_clamp_start_load: assert property (@(posedge mclk) disable iff (sys_rst)
    host_wr && host_addr == `VAMC_ADDR_CLAMP_START |=> ##1 clamp_start_pos == $past(host_wdata, 2))
    else $error("clamp start not loaded");

  a_clamp_stop_load: assert property (@(posedge mclk) disable iff (sys_rst)
    host_wr && host_addr == `VAMC_ADDR_CLAMP_STOP |=> ##1 clamp_stop_pos == $past(host_wdata, 2))
    else $error("clamp stop not loaded");

  a_win_stop_load: assert property (@(posedge mclk) disable iff (sys_rst)
    host_wr && host_addr == `VAMC_ADDR_WIN_STOP |=> ##1 acq_cfg.win_stop[7:0] == $past(host_wdata, 2))
    else $error("window stop low bits not loaded");

  a_fine_delay_load: assert property (@(posedge mclk) disable iff (sys_rst)
    host_wr && host_addr == `VAMC_ADDR_HORIZ_EXT |=> ##1 acq_cfg.fine_delay == $past(host_wdata[3:2], 2))
    else $error("fine delay not loaded");

  a_clk_phase_load: assert property (@(posedge mclk) disable iff (sys_rst)
    host_wr && host_addr == `VAMC_ADDR_HORIZ_EXT |=> ##1 acq_cfg.clk_phase == $past(host_wdata[4], 2))
    else $error("write clock phase not loaded");

  a_recog_dis_load: assert property (@(posedge mclk) disable iff (sys_rst)
    host_wr && host_addr == `VAMC_ADDR_HORIZ_EXT |=> ##1 acq_cfg.recog_disable == $past(host_wdata[6], 2))
    else $error("recognition disable not loaded");

  a_acq_double_load: assert property (@(posedge mclk) disable iff (sys_rst)
    host_wr && host_addr == `VAMC_ADDR_MODE_ZERO |=> ##1 mode_cfg.acq_double == $past(host_wdata[4], 2))
    else $error("doubled acquisition not loaded");

  a_pip_enable_load: assert property (@(posedge mclk) disable iff (sys_rst)
    host_wr && host_addr == `VAMC_ADDR_MODE_ZERO |=> ##1 mode_cfg.pip_enable == $past(host_wdata[5], 2))
    else $error("multi pip enable not loaded");

  a_pip_grid_load: assert property (@(posedge mclk) disable iff (sys_rst)
    host_wr && host_addr == `VAMC_ADDR_MODE_ZERO |=> ##1 mode_cfg.pip_grid_4x4 == $past(host_wdata[6], 2))
    else $error("multi pip grid not loaded");

  a_gen_mode_load: assert property (@(posedge mclk) disable iff (sys_rst)
    host_wr && host_addr == `VAMC_ADDR_MODE_ZERO |=> ##1 mode_cfg.generator_mode == $past(host_wdata[7], 2))
    else $error("generator mode not loaded");

  a_defl_mode_load: assert property (@(posedge mclk) disable iff (sys_rst)
    host_wr && host_addr == `VAMC_ADDR_MODE_ONE |=> ##1 mode_cfg.deflection_clockgen == $past(host_wdata[4], 2))
    else $error("deflection clock mode not loaded");

  a_ext_clock_load: assert property (@(posedge mclk) disable iff (sys_rst)
    host_wr && host_addr == `VAMC_ADDR_MODE_ONE |=> ##1 mode_cfg.external_acq_clock == $past(host_wdata[6], 2))
    else $error("external clock select not loaded");

  a_vert_rate_load: assert property (@(posedge mclk) disable iff (sys_rst)
    host_wr && host_addr == `VAMC_ADDR_MODE_ONE |=> ##1 mode_cfg.vert_rate_50 == $past(host_wdata[7], 2))
    else $error("vertical rate not loaded");

  a_disp_freq_36: assert property (@(posedge mclk) disable iff (sys_rst)
    mode_zero[3:2] == 2'b11 |=> mode_cfg.disp_freq == VAMC_DISP_36M0)
    else $error("display clock not 36 MHz");

  a_raster_aabb: assert property (@(posedge mclk) disable iff (sys_rst)
    !mode_one[7] && !single_clock_input && mode_one[0] |=> mode_cfg.disp_mode == VAMC_RASTER_AABB_100)
    else $error("aabb raster not decoded");

  a_single_clock_mode: assert property (@(posedge mclk) disable iff (sys_rst)
    mode_one[7] && single_clock_input && !mode_one[0] |=> mode_cfg.disp_mode == VAMC_SINGLE_312)
    else $error("single clock mode not decoded");

endmodule

// >>> sim/vamc_host_model.sv
// host microcontroller model driving the 8-bit register port
`timescale 1ns/10ps
module vamc_host_model (
  // clock
  input  wire logic       mclk,
  // host port
  output logic [7:0]      host_addr,
  output logic [7:0]      host_wdata,
  output logic            host_wr,
  output logic            host_rd,
  input  wire logic [7:0] host_rdata
);
  initial begin
    host_addr  = 8'h00;
    host_wdata = 8'h00;
    host_wr    = 1'b0;
    host_rd    = 1'b0;
  end
  // ----------------------------------------
  // bus cycles
  // ----------------------------------------
  // released lines show the inverse, so a stale value never looks valid
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    host_wr    <= 1'b1;
    host_addr  <= a;
    host_wdata <= d;
    @(posedge mclk);
    host_wr    <= 1'b0;
    host_addr  <= ~a;
    host_wdata <= ~d;
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    host_rd   <= 1'b1;
    host_addr <= a;
    @(posedge mclk);
    host_rd   <= 1'b0;
    host_addr <= ~a;
    @(posedge mclk);
    #1;
    d = host_rdata;
  endtask
endmodule

// >>> sim/test_video_acq_mode_config_regs.sv
// self-checking bench of the acquisition/mode register bank
`timescale 1ns/10ps
module test_video_acq_mode_config_regs;
  import vamc_pkg::*;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [2:0] s; logic [22:0] e;} vamc_row_t;
  logic             mclk = 1'b0;
  logic             sys_rst = 1'b1;
  logic [7:0]       host_addr, host_wdata, host_rdata, rd;
  logic             host_wr, host_rd;
  logic [9:0]       meas_field_length = 10'h000;
  logic             meas_length_valid = 1'b0;
  logic [1:0]       disp_field_count = 2'h0;
  logic             field_recog_result = 1'b0;
  logic             single_clock_input = 1'b0;
  logic             strobe = 1'b0;
  logic             hd = 1'b0;
  logic             vd = 1'b0;
  logic [7:0]       clamp_start_pos, clamp_stop_pos, vsync_sample_one_pos, vsync_sample_two_pos;
  vamc_acq_cfg_t    acq_cfg;
  vamc_mode_cfg_t   mode_cfg;
  logic             mem_one_input_enable, mem_two_write_enable, field_measure_enable, display_out_signal;
  int               err_total = 0;
  int               compares = 0;
  vamc_row_t rows [30] = '{
    '{8'h58, 8'hA5, 3'h0, 23'h0000A5}, '{8'h59, 8'h3C, 3'h1, 23'h00003C},
    '{8'h5D, 8'h7E, 3'h2, 23'h00007E}, '{8'h5E, 8'h81, 3'h3, 23'h000081},
    '{8'h5A, 8'hFF, 3'h4, 23'h3FC000}, '{8'h5B, 8'h01, 3'h4, 23'h3FC020},
    '{8'h5C, 8'h83, 3'h4, 23'h7FE020},
    '{8'h5C, 8'h0C, 3'h4, 23'h3FC038},
    '{8'h5C, 8'h10, 3'h4, 23'h3FC024},
    '{8'h5C, 8'h60, 3'h4, 23'h3FC023},
    '{8'h60, 8'h01, 3'h5, 23'h001000}, '{8'h60, 8'h02, 3'h5, 23'h002000},
    '{8'h60, 8'h03, 3'h5, 23'h003000}, '{8'h60, 8'h04, 3'h5, 23'h000000},
    '{8'h60, 8'h08, 3'h5, 23'h000400}, '{8'h60, 8'h0C, 3'h5, 23'h000800},
    '{8'h60, 8'h10, 3'h5, 23'h000200},
    '{8'h60, 8'h20, 3'h5, 23'h000100}, '{8'h60, 8'h60, 3'h5, 23'h000180},
    '{8'h60, 8'h80, 3'h5, 23'h000040}, '{8'h60, 8'h80, 3'h6, 23'h000006},
    '{8'h60, 8'h00, 3'h6, 23'h000007}, '{8'h61, 8'h02, 3'h6, 23'h000003},
    '{8'h61, 8'h04, 3'h6, 23'h000005},
    '{8'h61, 8'h10, 3'h5, 23'h000020},
    '{8'h61, 8'h40, 3'h5, 23'h000010},
    '{8'h61, 8'h80, 3'h5, 23'h00000A}, '{8'h61, 8'h81, 3'h5, 23'h00000B},
    '{8'h61, 8'h01, 3'h5, 23'h000001}, '{8'h61, 8'h00, 3'h5, 23'h000000}
  };

  always #10 mclk = ~mclk;

  vamc_host_model vamc_host_model_i (.mclk(mclk), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_wr(host_wr), .host_rd(host_rd), .host_rdata(host_rdata));
  vamc_regs vamc_regs_i (.mclk(mclk), .sys_rst(sys_rst), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_wr(host_wr), .host_rd(host_rd), .host_rdata(host_rdata), .meas_field_length(meas_field_length),
    .meas_length_valid(meas_length_valid), .disp_field_count(disp_field_count),
    .field_recog_result(field_recog_result), .single_clock_input(single_clock_input), .strobe(strobe),
    .horiz_display_signal(hd), .vert_display_signal(vd), .clamp_start_pos(clamp_start_pos),
    .clamp_stop_pos(clamp_stop_pos), .vsync_sample_one_pos(vsync_sample_one_pos),
    .vsync_sample_two_pos(vsync_sample_two_pos), .acq_cfg(acq_cfg), .mode_cfg(mode_cfg),
    .mem_one_input_enable(mem_one_input_enable), .mem_two_write_enable(mem_two_write_enable),
    .field_measure_enable(field_measure_enable), .display_out_signal(display_out_signal));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [22:0] view(input logic [2:0] s);
    case (s)
      3'h0: view = 23'(clamp_start_pos);
      3'h1: view = 23'(clamp_stop_pos);
      3'h2: view = 23'(vsync_sample_one_pos);
      3'h3: view = 23'(vsync_sample_two_pos);
      3'h4: view = acq_cfg;
      3'h5: view = 23'(mode_cfg);
      3'h6: view = 23'({mem_one_input_enable, mem_two_write_enable, field_measure_enable});
      default: view = 23'(display_out_signal);
    endcase
  endfunction
  task automatic check(input logic [22:0] got, input logic [22:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // fixed wait: config lands two edges after the write edge
  task automatic settle;
    repeat (3) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    vamc_host_model_i.write_reg(a, d);
    settle;
  endtask
  task automatic pulse_len(input logic [9:0] v);
    @(posedge mclk);
    meas_field_length <= v;
    meas_length_valid <= 1'b1;
    @(posedge mclk);
    meas_length_valid <= 1'b0;
  endtask
  task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
    vamc_host_model_i.read_reg(a, rd);
    check(23'(rd), 23'(exp));
  endtask
  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    conclude;
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 30; i++) begin
      wr(rows[i].a, rows[i].d);
      check(view(rows[i].s), rows[i].e);
    end
    // field information, both count bits and recognition
    disp_field_count   <= 2'h2;
    field_recog_result <= 1'b1;
    pulse_len(10'h2B5);
    rd_check(8'h81, 8'h1A);
    rd_check(8'h80, 8'hB5);
    disp_field_count   <= 2'h1;
    field_recog_result <= 1'b0;
    rd_check(8'h81, 8'h06);
    // generator mode stops the measurement
    wr(8'h60, 8'h80);
    pulse_len(10'h0F0);
    rd_check(8'h80, 8'hB5);
    wr(8'h60, 8'h00);
    pulse_len(10'h0F0);
    rd_check(8'h80, 8'hF0);
    // read-only, write-only and unmapped places
    wr(8'h80, 8'h55);
    rd_check(8'h80, 8'hF0);
    rd_check(8'h58, 8'h00);
    rd_check(8'h7F, 8'h00);
    // strobe overrides the memory one freeze
    wr(8'h61, 8'h02);
    strobe <= 1'b1;
    settle;
    check(view(3'h6), 23'h000007);
    strobe <= 1'b0;
    settle;
    check(view(3'h6), 23'h000003);
    // output signal select over every code and input pair
    for (int k = 0; k < 4; k++) begin
      wr(8'h61, {2'b00, k[1], 1'b0, k[0], 3'b000});
      for (int h = 0; h < 4; h++) begin
        hd <= h[0];
        vd <= h[1];
        settle;
        check(view(3'h7), 23'(k == 0 ? h[0] : (k == 1 ? h[1] : h[0] & h[1])));
      end
    end
    // single clock only with 50 Hz and raster clear
    wr(8'h61, 8'h80);
    single_clock_input <= 1'b1;
    settle;
    check(23'(mode_cfg.disp_mode), 23'(VAMC_SINGLE_312));
    single_clock_input <= 1'b0;
    // second reset in mid-run clears everything writable
    wr(8'h60, 8'hFF);
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    settle;
    check(view(3'h0), 23'h000000);
    check(view(3'h4), 23'h000000);
    check(view(3'h5), 23'h000000);
    check(view(3'h6), 23'h000007);
    conclude;
  end
endmodule
